// ---- design/irq_ctrl_core.sv ----
// Interrupt controller: flags, enables, vectoring sequence and AHB-Lite registers
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - Every reset clears the global enable so nothing vectors until software sets it again.
// - A source vectors only with global and own enable set, plus group enable for banks 1 to 3.
// - Each flag is set by its event whatever the state of any enable bit.
// - Taking an interrupt flushes the prefetched instruction and clears the global enable.
// - Taking an interrupt pushes the program counter and saves the core context.
// - Taking an interrupt loads the program counter with the fixed vector address.
// - With the global enable clear, events still set flags but never redirect execution.
// - A flag left pending while disabled is serviced as soon as the global enable returns.
// - The return instruction pops the address, restores context and sets the global enable.
// - Synchronous events reach the vector load three or four cycles after they occur.
// - Asynchronous events reach the vector load within three to five cycles.
// - The third flag register holds bits 5, 4, 2, 1 and 0 with bits 7, 6 and 3 read as zero.
module irq_ctrl_core
    import irq_pkg::*;
#(
    parameter int unsigned P_W = 8
) (
    input  wire logic                CLK_SYS_I,
    input  wire logic                RST_I,
    input  wire logic                CE_I,
    input  wire logic                HSEL_I,
    input  wire logic [31:0]         HADDR_I,
    input  wire logic [1:0]          HTRANS_I,
    input  wire logic                HWRITE_I,
    input  wire logic [2:0]          HSIZE_I,
    input  wire logic [31:0]         HWDATA_I,
    input  wire logic                HREADY_I,
    output logic                     HREADYOUT_O,
    output logic [31:0]              HRDATA_O,
    output logic                     HRESP_O,
    input  wire logic                EVT_CORE_I,
    input  wire logic [P_W-1:0]      EVT_PERIPH1_I,
    input  wire logic [P_W-1:0]      EVT_PERIPH2_I,
    input  wire logic [F3_SRC_W-1:0] EVT_ASYNC3_I,
    input  wire logic                CORE_BUSY_I,
    input  wire logic                RETURN_I,
    output logic                     FLUSH_O,
    output logic                     PUSH_PC_O,
    output logic                     CTX_SAVE_O,
    output logic                     VEC_LOAD_O,
    output logic [15:0]              VEC_ADDR_O,
    output logic                     POP_PC_O,
    output logic                     CTX_RESTORE_O,
    output logic                     GLOBAL_EN_O
);
    // Set wins over a software clear in the same cycle
    function automatic logic [P_W-1:0] merge_flags(input logic [P_W-1:0] old_v,
                                                   input logic            wr,
                                                   input logic [P_W-1:0] wval,
                                                   input logic [P_W-1:0] evt_v);
        merge_flags = (wr ? wval : old_v) | evt_v;
    endfunction

    function automatic logic [7:0] pack3(input logic [F3_SRC_W-1:0] v);
        pack3 = 8'h00;
        pack3[F3_WAVE_SHUTDOWN_BIT] = v[4];
        pack3[F3_ZERO_CROSS_BIT]    = v[3];
        pack3[F3_CELL_THREE_BIT]    = v[2];
        pack3[F3_CELL_TWO_BIT]      = v[1];
        pack3[F3_CELL_ONE_BIT]      = v[0];
    endfunction

    function automatic logic [F3_SRC_W-1:0] unpack3(input logic [7:0] b);
        unpack3 = {b[F3_WAVE_SHUTDOWN_BIT], b[F3_ZERO_CROSS_BIT], b[F3_CELL_THREE_BIT],
                   b[F3_CELL_TWO_BIT], b[F3_CELL_ONE_BIT]};
    endfunction

    async_evt_if #(.W(F3_SRC_W)) async3 ();

    irq_evt_sync #(.W(F3_SRC_W)) u_sync (
        .CLK_SYS_I (CLK_SYS_I),
        .RST_I     (RST_I),
        .CE_I      (CE_I),
        .evt       (async3.sync)
    );

    assign async3.raw = EVT_ASYNC3_I;

    logic                gie_q, gie_d;
    logic                group_en_q;
    logic                core_en_q;
    logic                core_flag_q, core_flag_d;
    logic [P_W-1:0]      flag1_q, flag1_d;
    logic [P_W-1:0]      flag2_q, flag2_d;
    logic [F3_SRC_W-1:0] flag3_q, flag3_d;
    logic [P_W-1:0]      en1_q;
    logic [P_W-1:0]      en2_q;
    logic [F3_SRC_W-1:0] en3_q;
    seq_state_t          state_q;
    logic                addr_ok;
    logic                wr_q;
    logic [7:0]          ofs_q;
    logic                wr_act;
    logic [7:0]          wbyte;
    logic                pend_any;
    logic                async_hit;
    logic                take_w;
    logic [31:0]         rd_word;

    // Bus address phase
    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I == HTRANS_NONSEQ && HSIZE_I == HSIZE_WORD;
    assign wr_act  = wr_q;
    assign wbyte   = HWDATA_I[7:0];

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            wr_q  <= 1'b0;
            ofs_q <= 8'h00;
        end else if (CE_I) begin
            wr_q  <= addr_ok && HWRITE_I && HADDR_I[31:8] == 24'h000000;
            ofs_q <= HADDR_I[7:0];
        end
    end

    // Flag next values
    assign core_flag_d = merge_flags(P_W'(core_flag_q), wr_act && ofs_q == OFS_CONTROL,
        P_W'(wbyte[CTRL_CORE_FLAG_BIT]), P_W'(EVT_CORE_I)) != '0;
    assign flag1_d = merge_flags(flag1_q, wr_act && ofs_q == OFS_FLAG1,
                                 wbyte[P_W-1:0], EVT_PERIPH1_I);
    assign flag2_d = merge_flags(flag2_q, wr_act && ofs_q == OFS_FLAG2,
                                 wbyte[P_W-1:0], EVT_PERIPH2_I);
    assign flag3_d = (wr_act && ofs_q == OFS_FLAG3 ? unpack3(wbyte) : flag3_q)
                   | async3.rise;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            core_flag_q <= 1'b0;
            flag1_q     <= P_W'(FLAG_RESET);
            flag2_q     <= P_W'(FLAG_RESET);
            flag3_q     <= F3_SRC_W'(FLAG_RESET);
        end else if (CE_I) begin
            core_flag_q <= core_flag_d;
            flag1_q     <= flag1_d;
            flag2_q     <= flag2_d;
            flag3_q     <= flag3_d;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            group_en_q <= 1'b0;
            core_en_q  <= 1'b0;
            en1_q      <= P_W'(ENABLE_RESET);
            en2_q      <= P_W'(ENABLE_RESET);
            en3_q      <= F3_SRC_W'(ENABLE_RESET);
        end else if (CE_I && wr_act) begin
            if (ofs_q == OFS_CONTROL) begin
                group_en_q <= wbyte[CTRL_GROUP_EN_BIT];
                core_en_q  <= wbyte[CTRL_CORE_EN_BIT];
            end
            if (ofs_q == OFS_ENABLE1) begin
                en1_q <= wbyte[P_W-1:0];
            end
            if (ofs_q == OFS_ENABLE2) begin
                en2_q <= wbyte[P_W-1:0];
            end
            if (ofs_q == OFS_ENABLE3) begin
                en3_q <= unpack3(wbyte);
            end
        end
    end

    // Pending request; async rise is bypassed so its path stays within budget
    assign async_hit = group_en_q && |(async3.rise & en3_q);
    assign pend_any  = (core_flag_q && core_en_q)
                     || (group_en_q && |({flag1_q & en1_q, flag2_q & en2_q, flag3_q & en3_q}))
                     || async_hit;
    assign take_w    = gie_q && pend_any && state_q == ST_RUN && !CORE_BUSY_I;

    // Global enable: software write, then return sets, then a take clears
    always_comb begin
        gie_d = gie_q;
        if (wr_act && ofs_q == OFS_CONTROL) begin
            gie_d = wbyte[CTRL_GLOBAL_EN_BIT];
        end
        if (RETURN_I) begin
            gie_d = 1'b1;
        end
        if (take_w) begin
            gie_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            gie_q <= 1'b0;
        end else if (CE_I) begin
            gie_q <= gie_d;
        end
    end

    // Vectoring sequence
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state_q    <= ST_RUN;
            FLUSH_O    <= 1'b0;
            PUSH_PC_O  <= 1'b0;
            CTX_SAVE_O <= 1'b0;
            VEC_LOAD_O <= 1'b0;
        end else if (CE_I) begin
            FLUSH_O    <= 1'b0;
            PUSH_PC_O  <= 1'b0;
            CTX_SAVE_O <= 1'b0;
            VEC_LOAD_O <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (take_w) begin
                        FLUSH_O    <= 1'b1;
                        PUSH_PC_O  <= 1'b1;
                        CTX_SAVE_O <= 1'b1;
                        state_q    <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    VEC_LOAD_O <= 1'b1;
                    state_q    <= ST_RUN;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Return path and status outputs
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            POP_PC_O      <= 1'b0;
            CTX_RESTORE_O <= 1'b0;
            VEC_ADDR_O    <= VECTOR_ADDR;
            GLOBAL_EN_O   <= 1'b0;
        end else if (CE_I) begin
            POP_PC_O      <= RETURN_I;
            CTX_RESTORE_O <= RETURN_I;
            VEC_ADDR_O    <= VECTOR_ADDR;
            GLOBAL_EN_O   <= gie_d;
        end
    end

    // Flag and global enable reads forwarded from next values so a write just before is seen
    always_comb begin
        rd_word = 32'h00000000;
        case (HADDR_I[7:0])
            OFS_CONTROL: begin
                rd_word[CTRL_GLOBAL_EN_BIT] = gie_d;
                rd_word[CTRL_GROUP_EN_BIT]  = group_en_q;
                rd_word[CTRL_CORE_EN_BIT]   = core_en_q;
                rd_word[CTRL_CORE_FLAG_BIT] = core_flag_d;
            end
            OFS_FLAG1:   rd_word[P_W-1:0] = flag1_d;
            OFS_FLAG2:   rd_word[P_W-1:0] = flag2_d;
            OFS_FLAG3:   rd_word[7:0]     = pack3(flag3_d);
            OFS_ENABLE1: rd_word[P_W-1:0] = en1_q;
            OFS_ENABLE2: rd_word[P_W-1:0] = en2_q;
            OFS_ENABLE3: rd_word[7:0]     = pack3(en3_q);
            default:     rd_word = 32'h00000000;
        endcase
        if (HADDR_I[31:8] != 24'h000000) begin
            rd_word = 32'h00000000;
        end
    end

    // Zero wait states; an unmapped address reads zero and writes are dropped
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            HRDATA_O    <= 32'h00000000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= HRESP_OKAY;
        end else if (CE_I) begin
            if (addr_ok && !HWRITE_I) begin
                HRDATA_O <= rd_word;
            end
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= HRESP_OKAY;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence s_sync_event;
        CE_I && !wr_act && gie_q && group_en_q && state_q == ST_RUN && !pend_any
            && |(EVT_PERIPH1_I & en1_q) && !addr_ok;
    endsequence

    sequence s_free_cycle;
        CE_I && !CORE_BUSY_I && !wr_act && !addr_ok;
    endsequence

    a_reset_disables: assert property ($past(RST_I) |-> !gie_q && !GLOBAL_EN_O)
        else $error("global enable not cleared by reset");
    a_take_gated: assert property ($rose(FLUSH_O) |-> $past(gie_q) && $past(pend_any))
        else $error("vector taken without enables");
    a_flag_capture: assert property (CE_I && |EVT_PERIPH2_I |=>
        (flag2_q & $past(EVT_PERIPH2_I)) == $past(EVT_PERIPH2_I))
        else $error("event lost from flag register");
    a_take_clears_en: assert property (FLUSH_O |-> !gie_q && PUSH_PC_O && CTX_SAVE_O)
        else $error("take did not clear enable or save context");
    a_vector_follows: assert property (FLUSH_O && CE_I |=>
        VEC_LOAD_O && VEC_ADDR_O == VECTOR_ADDR && !FLUSH_O)
        else $error("vector load missing after take");
    a_no_redirect: assert property (!gie_q |=> !FLUSH_O)
        else $error("redirect while globally disabled");
    a_pending_served: assert property (s_free_cycle and (gie_q && pend_any
        && state_q == ST_RUN) |=> FLUSH_O)
        else $error("pending interrupt not served");
    a_return_restores: assert property (CE_I && RETURN_I && !take_w |=>
        POP_PC_O && CTX_RESTORE_O && gie_q)
        else $error("return did not restore state");
    a_sync_latency: assert property (s_sync_event ##1 s_free_cycle ##1 CE_I |=>
        VEC_LOAD_O)
        else $error("synchronous latency out of range");
    a_async_latency: assert property (CE_I && async_hit && gie_q && state_q == ST_RUN
        && !CORE_BUSY_I |=> FLUSH_O ##1 (VEC_LOAD_O || !CE_I))
        else $error("asynchronous latency out of range");
    a_flag3_layout: assert property ($past(addr_ok && !HWRITE_I && HADDR_I == {24'h000000, OFS_FLAG3})
        && $past(CE_I) |-> HRDATA_O[7:6] == 2'h0 && HRDATA_O[3] == 1'h0)
        else $error("reserved flag bits read nonzero");
    a_flag3_reset: assert property ($past(RST_I) |-> flag3_q == '0)
        else $error("third flag register not reset");
endmodule

// ---- design/irq_evt_sync.sv ----
// Two-flop synchroniser with rising-edge detect for asynchronous event sources
`timescale 1ns/1ns
module irq_evt_sync #(
    parameter int unsigned W = 5
) (
    input  wire logic  CLK_SYS_I,
    input  wire logic  RST_I,
    input  wire logic  CE_I,
    async_evt_if.sync  evt
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;
    logic [W-1:0] last_q;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            meta_q   <= '0;
            stable_q <= '0;
            last_q   <= '0;
        end else if (CE_I) begin
            meta_q   <= evt.raw;
            stable_q <= meta_q;
            last_q   <= stable_q;
        end
    end

    // Edge taken after the second flop only, so no logic sees a metastable value
    assign evt.rise = stable_q & ~last_q;
endmodule

// ---- pkg/async_evt_if.sv ----
// Carrier between the controller and its asynchronous event synchroniser
`timescale 1ns/1ns
interface async_evt_if #(
    parameter int unsigned W = 5
);
    logic [W-1:0] raw;
    logic [W-1:0] rise;

    modport ctrl (output raw, input rise);
    modport sync (input raw, output rise);
endinterface

// ---- pkg/irq_pkg.sv ----
// Constants and types shared by the interrupt controller files
package irq_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_FLAG1   = 8'h04;
    localparam logic [7:0] OFS_FLAG2   = 8'h08;
    localparam logic [7:0] OFS_FLAG3   = 8'h0C;
    localparam logic [7:0] OFS_ENABLE1 = 8'h10;
    localparam logic [7:0] OFS_ENABLE2 = 8'h14;
    localparam logic [7:0] OFS_ENABLE3 = 8'h18;

    // Control register field positions
    localparam int unsigned CTRL_GLOBAL_EN_BIT = 7;
    localparam int unsigned CTRL_GROUP_EN_BIT  = 6;
    localparam int unsigned CTRL_CORE_EN_BIT   = 1;
    localparam int unsigned CTRL_CORE_FLAG_BIT = 0;

    // Third flag register field positions
    localparam int unsigned F3_WAVE_SHUTDOWN_BIT = 5;
    localparam int unsigned F3_ZERO_CROSS_BIT    = 4;
    localparam int unsigned F3_CELL_THREE_BIT    = 2;
    localparam int unsigned F3_CELL_TWO_BIT      = 1;
    localparam int unsigned F3_CELL_ONE_BIT      = 0;
    localparam int unsigned F3_SRC_W             = 5;

    // Reset values
    localparam logic [7:0] FLAG_RESET   = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // Fixed interrupt vector
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;

    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_VECTOR
    } seq_state_t;

endpackage

// ---- tb/core_model.sv ----
// Core fetch and program counter model facing the interrupt controller
`timescale 1ns/1ns
module core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        push_i,
    input  wire logic        vec_load_i,
    input  wire logic [15:0] vec_addr_i,
    input  wire logic        pop_i,
    input  wire logic        busy_req_i,
    input  wire logic        ret_req_i,
    output logic             busy_o,
    output logic             ret_o,
    output logic [3:0]       depth_o,
    output logic [7:0]       vcnt_o,
    output logic             err_o
);
    logic [15:0] pc_q;
    logic [15:0] stack_q [8];

    // Two-cycle instruction marker, one cycle wide
    assign busy_o = busy_req_i;
    assign ret_o  = ret_req_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_q    <= 16'h0000;
            depth_o <= 4'h0;
            vcnt_o  <= 8'h00;
            err_o   <= 1'b0;
        end else begin
            pc_q <= pc_q + 16'h0001;
            if (push_i) begin
                stack_q[depth_o[2:0]] <= pc_q;
                depth_o               <= depth_o + 4'h1;
            end
            if (vec_load_i) begin
                pc_q   <= vec_addr_i;
                vcnt_o <= vcnt_o + 8'h01;
            end
            // Popping an empty stack means an unbalanced return
            if (pop_i) begin
                err_o   <= err_o | (depth_o == 4'h0);
                pc_q    <= stack_q[depth_o[2:0] - 3'h1];
                depth_o <= depth_o - 4'h1;
            end
        end
    end
endmodule

// ---- tb/irq_ctrl_core_tb.sv ----
// Self-checking bench for the interrupt controller core
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module irq_ctrl_core_tb import irq_pkg::*; ;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic        evt_core = 1'b0;
    logic [7:0]  evt1 = 8'h00;
    logic [7:0]  evt2 = 8'h00;
    logic [4:0]  evt3 = 5'h00;
    logic        busy_req = 1'b0;
    logic        ret_req = 1'b0;
    logic        hready, hresp, busy, ret, flush, push, ctx;
    logic        vec_load, pop, restore, glob_en, err;
    logic [31:0] hrdata;
    logic [15:0] vec_addr;
    logic [3:0]  depth;
    logic [7:0]  vcnt;
    logic [7:0]  v0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          k;

    always #4 clk_sys = ~clk_sys;

    irq_ctrl_core dut_u (
        .CLK_SYS_I(clk_sys), .RST_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp),
        .EVT_CORE_I(evt_core), .EVT_PERIPH1_I(evt1), .EVT_PERIPH2_I(evt2),
        .EVT_ASYNC3_I(evt3), .CORE_BUSY_I(busy), .RETURN_I(ret), .FLUSH_O(flush),
        .PUSH_PC_O(push), .CTX_SAVE_O(ctx), .VEC_LOAD_O(vec_load), .VEC_ADDR_O(vec_addr),
        .POP_PC_O(pop), .CTX_RESTORE_O(restore), .GLOBAL_EN_O(glob_en)
    );

    core_model model_u (
        .clk_i(clk_sys), .rst_i(rst), .push_i(push), .vec_load_i(vec_load),
        .vec_addr_i(vec_addr), .pop_i(pop), .busy_req_i(busy_req), .ret_req_i(ret_req),
        .busy_o(busy), .ret_o(ret), .depth_o(depth), .vcnt_o(vcnt), .err_o(err)
    );

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // No wait count assumed; a stuck hready is left to the watchdog
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        `CHK(r, e)
        `CHK(hresp, HRESP_OKAY)
    endtask

    // Kind 3 launches nothing: the request is already pending
    task automatic measure(input int kind, input bit b, output int n);
        logic [2:0] f_prev;
        f_prev = 3'b000;
        n = 0;
        if (kind != 3) begin
            @(posedge clk_sys);
            case (kind)
                0: evt1 <= 8'h01;
                1: evt_core <= 1'b1;
                default: evt3 <= 5'h08;
            endcase
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            evt1     <= 8'h00;
            evt_core <= 1'b0;
            busy_req <= b && (n == 0);
            #1;
            n++;
            if (vec_load === 1'b1) break;
            f_prev = {flush, push, ctx};
        end
        `CHK(f_prev, 3'b111)
        `CHK(glob_en, 1'b0)
        `CHK(vec_addr, VECTOR_ADDR)
    endtask

    task automatic do_return();
        @(posedge clk_sys);
        ret_req <= 1'b1;
        @(posedge clk_sys);
        ret_req <= 1'b0;
        #1;
        `CHK({pop, restore, glob_en}, 3'b111)
    endtask

    task automatic pulse1();
        @(posedge clk_sys);
        evt1 <= 8'h01;
        @(posedge clk_sys);
        evt1 <= 8'h00;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        `CHK(glob_en, 1'b0)
        `CHK(vec_addr, VECTOR_ADDR)
        rd_chk(OFS_CONTROL, 32'h0);
        rd_chk(OFS_FLAG3, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(OFS_FLAG3, 32'hFF);
        rd_chk(OFS_FLAG3, 32'h37);
        wr(OFS_FLAG3, 32'h0);
        rd_chk(OFS_FLAG3, 32'h0);
        wr(OFS_ENABLE3, 32'hFF);
        rd_chk(OFS_ENABLE3, 32'h37);
        wr(OFS_ENABLE3, 32'h0);
        rd_chk(8'h80, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_quiet();
        @(posedge clk_sys);
        evt1     <= 8'hA5;
        evt2     <= 8'h5A;
        evt3     <= 5'h1F;
        evt_core <= 1'b1;
        @(posedge clk_sys);
        evt1     <= 8'h00;
        evt2     <= 8'h00;
        evt_core <= 1'b0;
        repeat (6) @(posedge clk_sys);
        evt3 <= 5'h00;
        rd_chk(OFS_FLAG1, 32'hA5);
        rd_chk(OFS_FLAG2, 32'h5A);
        rd_chk(OFS_FLAG3, 32'h37);
        rd_chk(OFS_CONTROL, 32'h01);
        `CHK(vcnt, 8'h00)
        wr(OFS_FLAG1, 32'h0);
        wr(OFS_FLAG2, 32'h0);
        wr(OFS_FLAG3, 32'h0);
        wr(OFS_CONTROL, 32'h0);
        $display("test quiet flags done");
    endtask

    task automatic t_sync(input bit b);
        wr(OFS_FLAG1, 32'h0);
        wr(OFS_ENABLE1, 32'h1);
        wr(OFS_CONTROL, 32'hC0);
        measure(0, b, k);
        `CHK(k, b ? 4 : 3)
        `CHK(depth, 4'h1)
        do_return();
        measure(3, 1'b0, k);
        `CHK(k, 2)
        wr(OFS_FLAG1, 32'h0);
        do_return();
        v0 = vcnt;
        repeat (4) @(posedge clk_sys);
        `CHK(vcnt, v0)
        `CHK(depth, 4'h0)
        $display("test sync latency done");
    endtask

    task automatic t_core();
        wr(OFS_CONTROL, 32'h80);
        v0 = vcnt;
        pulse1();
        `CHK(vcnt, v0)
        rd_chk(OFS_FLAG1, 32'h01);
        wr(OFS_FLAG1, 32'h0);
        wr(OFS_CONTROL, 32'h82);
        measure(1, 1'b0, k);
        `CHK(k, 3)
        wr(OFS_CONTROL, 32'h02);
        do_return();
        rd_chk(OFS_CONTROL, 32'h82);
        $display("test core source done");
    endtask

    task automatic t_pending();
        wr(OFS_CONTROL, 32'h40);
        v0 = vcnt;
        pulse1();
        `CHK(vcnt, v0)
        wr(OFS_CONTROL, 32'hC0);
        measure(3, 1'b0, k);
        `CHK(k <= 3, 1'b1)
        wr(OFS_FLAG1, 32'h0);
        do_return();
        $display("test pending done");
    endtask

    task automatic t_async();
        wr(OFS_ENABLE3, 32'h10);
        wr(OFS_CONTROL, 32'hC0);
        measure(2, 1'b0, k);
        `CHK(k >= 3 && k <= 5, 1'b1)
        @(posedge clk_sys);
        evt3 <= 5'h00;
        rd_chk(OFS_FLAG3, 32'h10);
        wr(OFS_FLAG3, 32'h0);
        do_return();
        `CHK(err, 1'b0)
        $display("test async done");
    endtask

    // Bit 4 is left out so the write cannot vector before the reset
    task automatic t_rereset();
        wr(OFS_FLAG3, 32'h27);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK(glob_en, 1'b0)
        rd_chk(OFS_CONTROL, 32'h0);
        rd_chk(OFS_FLAG3, 32'h0);
        rd_chk(OFS_ENABLE3, 32'h0);
        $display("test second reset done");
    endtask

    initial begin
        #40000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_quiet();
        t_sync(1'b0);
        t_sync(1'b1);
        t_core();
        t_pending();
        t_async();
        t_rereset();
        summarize();
    end
endmodule
